// file: design/ocr_pkg.sv
// Package of constants and types for the operational control register group
package ocr_pkg;

    // ***************************************************************
    // Register bus
    // ***************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] POWER_DOWN_AND_SOFT_RESET_OFS = 12'hA00;
    localparam logic [11:0] LOOP_MODE_CONTROL_OFS = 12'hA01;
    localparam logic [11:0] OUTPUT_SYNC_CONTROL_OFS = 12'hA02;

    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int PD_SOFT_RESET_BIT = 7;
    localparam int PD_OSC_BIT = 6;
    localparam int PD_SYSTEM_CLOCK_INPUT_BIT = 5;
    localparam int PD_REF_BIT = 4;
    localparam int PD_TDC_BIT = 3;
    localparam int PD_OUT_LOOP_BIT = 2;
    localparam int PD_DIST_BIT = 1;
    localparam int PD_FULL_BIT = 0;
    localparam int LM_HOLDOVER_BIT = 6;
    localparam int LM_FREERUN_BIT = 5;
    localparam int LM_MODE_HI = 4;
    localparam int LM_MODE_LO = 2;
    localparam int LM_REF_HI = 1;
    localparam int LM_REF_LO = 0;
    localparam int SYNC_SOFT_BIT = 1;

    // ***************************************************************
    // Reset values and writable masks
    // ***************************************************************
    localparam logic [7:0] PD_RESET = 8'h00;
    localparam logic [7:0] LM_RESET = 8'h00;
    localparam logic [7:0] SYNC_RESET = 8'h00;
    localparam logic [7:0] PD_MASK = 8'hFF;
    localparam logic [7:0] LM_MASK = 8'h7F;
    localparam logic [7:0] SYNC_MASK = 8'h02;
    localparam int SOFT_RESET_CYCLES = 1;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef enum logic [2:0] {
        OCR_AUTO_REVERT = 3'h0,
        OCR_AUTO_NONREVERT = 3'h1,
        OCR_MANUAL_FALLBACK = 3'h2,
        OCR_MANUAL_HOLDOVER = 3'h3,
        OCR_FULL_MANUAL = 3'h4
    } ocr_switch_mode_t;

    typedef enum logic [1:0] {
        OCR_LOOP_CLOSED,
        OCR_LOOP_HOLDOVER,
        OCR_LOOP_FREERUN
    } ocr_loop_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ocr_bus_req_t;

    typedef struct packed {
        logic soft_reset;
        logic osc_sleep;
        logic system_clock_input_sleep;
        logic ref_sleep;
        logic tdc_sleep;
        logic out_loop_sleep;
        logic dist_sleep;
        logic chip_sleep;
    } ocr_power_t;

    typedef struct packed {
        ocr_loop_state_t loop_state;
        ocr_switch_mode_t switch_mode;
        logic mode_valid;
        logic manual_sel;
        logic [1:0] ref_sel;
    } ocr_loop_t;

    typedef struct packed {
        logic stall;
        logic restart;
    } ocr_sync_t;

endpackage

// file: design/ocr_regs.sv
// Operational control register group: power-down, loop mode, soft sync
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
// Contract
// - Soft reset bit resets operating logic but keeps register contents.
// - Bit 6 puts the controlled oscillator into deep sleep.
// - Bit 5 puts system clock input and multiplier loop into sleep.
// - Bit 4 puts all reference inputs into deep sleep.
// - Bit 3 puts the time-to-digital converter into deep sleep.
// - Bit 2 puts the output analog loop into deep sleep.
// - Bit 1 puts the clock distribution outputs into deep sleep.
// - Bit 0 sleeps the whole chip regardless of block bits.
// - User holdover bit forces holdover from stored history word.
// - User free-run bit forces free run from free-run word.
// - Free run wins when both free run and holdover are set.
// - Bits 4..2 pick the switchover mode; 101..111 unused.
// - Manual modes select reference A..D from bits 1..0.
// - Soft sync bit at 1 stalls non-masked distribution outputs.
// - Change of soft sync from 1 to 0 restarts outputs together.
module ocr_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input ocr_pkg::ocr_bus_req_t bus_i,
    output logic [ocr_pkg::DATA_W-1:0] rdata_o,
    // Chip controls
    output logic core_rst_o,
    output ocr_pkg::ocr_power_t power_o,
    output ocr_pkg::ocr_loop_t loop_o,
    output ocr_pkg::ocr_sync_t sync_o
);
    import ocr_pkg::*;

    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        logic [7:0] pd;
        logic [7:0] lm;
        logic [7:0] sync;
        logic [7:0] rdata;
        logic core_rst;
        ocr_power_t power;
        ocr_loop_t loop;
    } ocr_state_t;

    ocr_state_t state_reg;
    ocr_state_t state_next;
    ocr_sync_t sync_w;

    // ***************************************************************
    // Register map
    // ***************************************************************
    // Power-down and soft reset, one bit per block:
    //   7 soft reset of the operating logic, register contents kept
    //   6 controlled oscillator asleep
    //   5 system clock input and its multiplier loop asleep
    //   4 all reference inputs asleep
    //   3 time-to-digital converter asleep
    //   2 output analog loop asleep
    //   1 clock distribution outputs asleep
    //   0 whole chip asleep, overriding every block bit
    // Loop mode control:
    //   7 reserved, reads zero
    //   6 forced holdover
    //   5 forced free run, wins over forced holdover
    //   4..2 switchover mode, codes above full manual unused
    //   1..0 manually selected reference, A to D
    // Output sync control:
    //   7..2 and 0 reserved, read zero
    //   1 soft sync: outputs stall while set, restart on its fall

    // ***************************************************************
    // Address decode
    // ***************************************************************
    typedef enum logic [1:0] {
        OCR_SEL_NONE,
        OCR_SEL_PD,
        OCR_SEL_LM,
        OCR_SEL_SYNC
    } ocr_sel_t;

    ocr_sel_t wr_sel;
    ocr_sel_t rd_sel;

    // Register addressed by a bus offset; unmapped offsets hit nothing
    function automatic ocr_sel_t ocr_decode(input logic [ADDR_W-1:0] a);
        ocr_sel_t s;
        s = OCR_SEL_NONE;
        case (a)
            POWER_DOWN_AND_SOFT_RESET_OFS: s = OCR_SEL_PD;
            LOOP_MODE_CONTROL_OFS: s = OCR_SEL_LM;
            OUTPUT_SYNC_CONTROL_OFS: s = OCR_SEL_SYNC;
            default: s = OCR_SEL_NONE;
        endcase
        return s;
    endfunction

    assign wr_sel = bus_i.wr ? ocr_decode(bus_i.addr) : OCR_SEL_NONE;
    assign rd_sel = bus_i.rd ? ocr_decode(bus_i.addr) : OCR_SEL_NONE;

    // ***************************************************************
    // Register write path
    // ***************************************************************
    logic [DATA_W-1:0] pd_new;
    logic [DATA_W-1:0] lm_new;
    logic [DATA_W-1:0] sync_new;

    // Reserved bits are masked on the way in, so they never reach a control
    assign pd_new = (wr_sel == OCR_SEL_PD) ? (bus_i.wdata & PD_MASK) : state_reg.pd;
    assign lm_new = (wr_sel == OCR_SEL_LM) ? (bus_i.wdata & LM_MASK) : state_reg.lm;
    assign sync_new = (wr_sel == OCR_SEL_SYNC) ? (bus_i.wdata & SYNC_MASK)
        : state_reg.sync;

    // ***************************************************************
    // Power-down decode
    // ***************************************************************
    localparam int N_BLOCKS = PD_OSC_BIT - PD_DIST_BIT + 1;

    logic [N_BLOCKS-1:0] block_sleep;
    logic chip_sleep_w;

    assign chip_sleep_w = pd_new[PD_FULL_BIT];

    // Every block bit is forced by the whole-chip bit
    for (genvar g = 0; g < N_BLOCKS; g++) begin : gen_block_sleep
        assign block_sleep[g] = pd_new[PD_DIST_BIT + g] | chip_sleep_w;
    end

    // ***************************************************************
    // Loop mode decode
    // ***************************************************************
    logic [2:0] mode_new;

    assign mode_new = lm_new[LM_MODE_HI:LM_MODE_LO];

    // Switchover modes in which the reference comes from the register
    function automatic logic ocr_is_manual(input logic [2:0] mode);
        logic m;
        m = 1'b0;
        case (mode)
            OCR_MANUAL_FALLBACK, OCR_MANUAL_HOLDOVER, OCR_FULL_MANUAL: m = 1'b1;
            default: m = 1'b0;
        endcase
        return m;
    endfunction

    // Codes above full manual are unused and flagged as such
    function automatic logic ocr_mode_known(input logic [2:0] mode);
        return (mode <= OCR_FULL_MANUAL);
    endfunction

    // Forced loop state; free run wins over holdover
    function automatic ocr_loop_state_t ocr_forced_state(input logic [DATA_W-1:0] lm);
        ocr_loop_state_t st;
        st = OCR_LOOP_CLOSED;
        if (lm[LM_FREERUN_BIT]) begin
            st = OCR_LOOP_FREERUN;
        end else if (lm[LM_HOLDOVER_BIT]) begin
            st = OCR_LOOP_HOLDOVER;
        end else begin
            st = OCR_LOOP_CLOSED;
        end
        return st;
    endfunction

    // ***************************************************************
    // Readback
    // ***************************************************************
    // Value of the addressed register, zero for unmapped offsets
    function automatic logic [DATA_W-1:0] ocr_read(input ocr_sel_t sel, input ocr_state_t s);
        logic [DATA_W-1:0] v;
        v = 8'h00;
        case (sel)
            OCR_SEL_PD: v = s.pd;
            OCR_SEL_LM: v = s.lm & LM_MASK;
            OCR_SEL_SYNC: v = s.sync & SYNC_MASK;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ***************************************************************
    // Next state
    // ***************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.pd = pd_new;
        state_next.lm = lm_new;
        state_next.sync = sync_new;
        state_next.rdata = ocr_read(rd_sel, state_reg);
        // Soft reset is a level while the bit is set; registers keep values
        state_next.core_rst = pd_new[PD_SOFT_RESET_BIT];
        state_next.power.soft_reset = pd_new[PD_SOFT_RESET_BIT];
        state_next.power.osc_sleep = block_sleep[PD_OSC_BIT - PD_DIST_BIT];
        state_next.power.system_clock_input_sleep = block_sleep[PD_SYSTEM_CLOCK_INPUT_BIT - PD_DIST_BIT];
        state_next.power.ref_sleep = block_sleep[PD_REF_BIT - PD_DIST_BIT];
        state_next.power.tdc_sleep = block_sleep[PD_TDC_BIT - PD_DIST_BIT];
        state_next.power.out_loop_sleep = block_sleep[PD_OUT_LOOP_BIT - PD_DIST_BIT];
        state_next.power.dist_sleep = block_sleep[0];
        state_next.power.chip_sleep = chip_sleep_w;
        state_next.loop.loop_state = ocr_forced_state(lm_new);
        state_next.loop.switch_mode = ocr_switch_mode_t'(mode_new);
        state_next.loop.mode_valid = ocr_mode_known(mode_new);
        state_next.loop.manual_sel = ocr_is_manual(mode_new);
        state_next.loop.ref_sel = lm_new[LM_REF_HI:LM_REF_LO];
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
            state_reg.pd <= PD_RESET;
            state_reg.lm <= LM_RESET;
            state_reg.sync <= SYNC_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ***************************************************************
    // Soft sync of the distribution
    // ***************************************************************
    ocr_sync_ctrl u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .sync_bit_i(state_reg.sync[SYNC_SOFT_BIT]),
        .sync_o(sync_w)
    );

    assign rdata_o = state_reg.rdata;
    assign core_rst_o = state_reg.core_rst;
    assign power_o = state_reg.power;
    assign loop_o = state_reg.loop;
    assign sync_o = sync_w;

endmodule

// file: design/ocr_sync_ctrl.sv
// Soft sync stall and restart pulse for the clock distribution
`timescale 1ns/1ps
module ocr_sync_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic sync_bit_i,
    // Distribution
    output ocr_pkg::ocr_sync_t sync_o
);
    import ocr_pkg::*;

    typedef struct packed {
        logic prev;
        ocr_sync_t out;
    } ocr_sync_state_t;

    ocr_sync_state_t state_reg;
    ocr_sync_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.prev = sync_bit_i;
        state_next.out.stall = sync_bit_i;
        state_next.out.restart = state_reg.prev & ~sync_bit_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_o = state_reg.out;

endmodule

// file: verif/ocr_regs_asserts.sv
// Port assertions for the operational control register group
`timescale 1ns/1ps
module ocr_regs_asserts (
    // Clock, reset and register port
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input ocr_pkg::ocr_bus_req_t bus_i,
    input wire logic [ocr_pkg::DATA_W-1:0] rdata_o,
    // Chip controls
    input wire logic core_rst_o,
    input ocr_pkg::ocr_power_t power_o,
    input ocr_pkg::ocr_loop_t loop_o,
    input ocr_pkg::ocr_sync_t sync_o
);
    import ocr_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic w_pd;
    logic w_lm;
    logic w_sync;
    assign w_pd = bus_i.wr && bus_i.addr == POWER_DOWN_AND_SOFT_RESET_OFS;
    assign w_lm = bus_i.wr && bus_i.addr == LOOP_MODE_CONTROL_OFS;
    assign w_sync = bus_i.wr && bus_i.addr == OUTPUT_SYNC_CONTROL_OFS;
    chk_idle_rdata: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    chk_soft_reset: assert property (w_pd |=> core_rst_o == $past(bus_i.wdata[7]))
        else $error("soft reset does not follow bit 7");
    chk_osc_sleep: assert property (w_pd |=> power_o.osc_sleep ==
        ($past(bus_i.wdata[6]) || $past(bus_i.wdata[0]))) else $error("oscillator sleep wrong");
    chk_chip_sleep: assert property (power_o.chip_sleep |-> power_o[6:1] == 6'h3F)
        else $error("chip sleep leaves a block awake");
    chk_loop_force: assert property (w_lm |=> loop_o.loop_state == ($past(bus_i.wdata[5]) ?
        OCR_LOOP_FREERUN : $past(bus_i.wdata[6]) ? OCR_LOOP_HOLDOVER : OCR_LOOP_CLOSED))
        else $error("loop state wrong");
    chk_manual_sel: assert property (w_lm |=> loop_o.manual_sel ==
        ($past(bus_i.wdata[4:2]) inside {3'h2, 3'h3, 3'h4})) else $error("manual select wrong");
    chk_stall_set: assert property (w_sync && bus_i.wdata[SYNC_SOFT_BIT]
        |-> ##2 sync_o.stall) else $error("stall not raised");
    chk_restart_pulse: assert property (sync_o.restart |-> $fell(sync_o.stall) ##1
        !sync_o.restart) else $error("restart pulse wrong");
endmodule

bind ocr_regs ocr_regs_asserts u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .core_rst_o(core_rst_o), .power_o(power_o), .loop_o(loop_o),
    .sync_o(sync_o));

// file: verif/operational_control_regs_test.sv
// Self-checking bench for the operational control register group
`timescale 1ns/1ps
module operational_control_regs_test;
    import ocr_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    ocr_bus_req_t bus = '0;
    logic [7:0] rdata;
    logic core_rst;
    ocr_power_t power;
    ocr_loop_t loop;
    ocr_sync_t sync;
    int fails = 0;
    int n_checks = 0;
    always #5 clk_i = ~clk_i;
    ocr_regs DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata),
        .core_rst_o(core_rst), .power_o(power), .loop_o(loop), .sync_o(sync));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic t_power();
        logic [7:0] v;
        check({core_rst, power}, 9'h000);
        check({loop, sync}, 11'h000);
        wr(12'hA01, 8'h0E);
        for (int b = 7; b >= 0; b--) begin
            v = 8'h01 << b;
            wr(12'hA00, v);
            check(power, {v[7], v[6:1] | {6{v[0]}}, v[0]});
            check(core_rst, v[7]);
            rd(12'hA00, v);
            rd(12'hA01, 8'h0E);
        end
        wr(12'hA00, 8'h00);
    endtask
    task automatic t_loop();
        logic [2:0] m;
        logic [7:0] w;
        for (int i = 0; i < 16; i++) begin
            m = 3'(i);
            w = {1'b1, m[1], m[0], m, 2'(i >> 2)};
            wr(12'hA01, w);
            check(loop.loop_state, m[0] ? 2'd2 : m[1] ? 2'd1 : 2'd0);
            check({loop.switch_mode, loop.mode_valid}, {m, m <= 3'h4});
            check(loop.manual_sel, m inside {3'h2, 3'h3, 3'h4});
            if (m inside {3'h2, 3'h3, 3'h4}) begin
                check(loop.ref_sel, w[1:0]);
            end
            rd(12'hA01, {1'b0, w[6:0]});
        end
    endtask
    task automatic t_sync();
        wr(12'hA02, 8'hFF);
        check(sync, 2'b00);
        step();
        check(sync, 2'b10);
        rd(12'hA02, 8'h02);
        wr(12'hA02, 8'hFD);
        check(sync, 2'b10);
        step();
        check(sync, 2'b01);
        step();
        check(sync, 2'b00);
        wr(12'hA03, 8'hFF);
        rd(12'hA03, 8'h00);
        rd(12'hA00, 8'h00);
    endtask
    task automatic t_reset();
        wr(12'hA00, 8'hFE);
        wr(12'hA01, 8'h7F);
        wr(12'hA02, 8'h02);
        step();
        check(sync, 2'b10);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        check({core_rst, power}, 9'h000);
        check({loop, sync}, 11'h000);
        rd(12'hA00, 8'h00);
        rd(12'hA01, 8'h00);
        rd(12'hA02, 8'h00);
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        t_power();
        t_loop();
        t_sync();
        t_reset();
        print_verdict();
    end
    initial begin
        #20000;
        fails++;
        print_verdict();
    end
endmodule
